/* File: design/pmir_pkg.sv */
// Package: command codes, reset values and limits of the ident/telemetry bank
package pmir_pkg;
    // Command codes
    localparam logic [7:0] CMD_MEAS_FREQ = 8'h95;
    localparam logic [7:0] CMD_SPEC_VER = 8'h98;
    localparam logic [7:0] CMD_MAKER_STR = 8'h99;
    localparam logic [7:0] CMD_MODEL_STR = 8'h9a;
    localparam logic [7:0] CMD_VERSION_STR = 8'h9b;
    localparam logic [7:0] CMD_SITE_STR = 8'h9c;
    localparam logic [7:0] CMD_BUILD_DAY_STR = 8'h9d;
    localparam logic [7:0] CMD_UNIT_NUM_STR = 8'h9e;
    localparam logic [7:0] CMD_CHIP_IDENTITY = 8'had;
    localparam logic [7:0] CMD_CHIP_FW_VER = 8'hae;
    localparam logic [7:0] CMD_SCRATCH_STR = 8'hb0;
    localparam logic [7:0] CMD_RAMP_FLOOR = 8'hce;

    // Spec revision byte fields and value
    localparam int SPEC_PART1_MSB = 7;
    localparam int SPEC_PART1_LSB = 4;
    localparam int SPEC_PART2_MSB = 3;
    localparam int SPEC_PART2_LSB = 0;
    localparam logic [3:0] SPEC_REV_1_2 = 4'h2;
    localparam logic [7:0] SPEC_VER_VALUE = 8'h22;

    // Linear-11 layout
    localparam int LIN11_EXP_MSB = 15;
    localparam int LIN11_EXP_LSB = 11;
    localparam int LIN11_MANT_MSB = 10;
    localparam int LIN11_MANT_LSB = 0;

    // Reset values
    localparam logic [15:0] RAMP_FLOOR_RESET = 16'h0000;
    localparam logic [5:0] STR_LEN_RESET = 6'h00;
    localparam logic [7:0] BUDGET_RESET = 8'h00;

    // String store geometry and shared budget
    localparam int STR_COUNT = 7;
    localparam int STR_MAX_LEN = 32;
    localparam logic [5:0] STR_MAX_LEN_B = 6'h20;
    localparam logic [8:0] STR_BUDGET = 9'h080;
    localparam logic [7:0] STR_OVERHEAD = 8'h01;
    localparam logic [5:0] BLOCK4_LEN = 6'h04;
    localparam logic [5:0] WORD_LEN = 6'h02;
    localparam int PAGE_COUNT = 2;

    // Answer to a read past the data or of an unknown command
    localparam logic [7:0] RD_FILL = 8'hff;
endpackage : pmir_pkg

/* File: design/pmir_string_store.sv */
// String store: seven user strings of up to 32 bytes with their lengths
`timescale 1ns/1ps
module pmir_string_store (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Byte write port
    input wire logic wr_en,
    input wire logic [2:0] wr_sel,
    input wire logic [4:0] wr_idx,
    input wire logic [7:0] wr_data,
    // Length update
    input wire logic len_set,
    input wire logic [5:0] len_val,
    // Read port, combinational
    input wire logic [2:0] rd_sel,
    input wire logic [4:0] rd_idx,
    output logic [7:0] rd_data,
    output logic [pmir_pkg::STR_COUNT-1:0][5:0] lens
);
    typedef struct packed {
        logic [pmir_pkg::STR_COUNT*pmir_pkg::STR_MAX_LEN-1:0][7:0] mem;
        logic [pmir_pkg::STR_COUNT-1:0][5:0] len;
    } pmir_store_t;

    pmir_store_t st_reg;
    pmir_store_t st_next;

    // Byte and length updates; contents are not cleared, only lengths
    always_comb begin
        st_next = st_reg;
        if (wr_en && wr_sel < 3'(pmir_pkg::STR_COUNT)) begin
            st_next.mem[{wr_sel, wr_idx}] = wr_data;
        end
        if (len_set && wr_sel < 3'(pmir_pkg::STR_COUNT)) begin
            st_next.len[wr_sel] = len_val;
        end
    end

    // Strings start empty after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg.len <= '0;
            st_reg.mem <= st_next.mem;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_data = (rd_sel < 3'(pmir_pkg::STR_COUNT)) ? st_reg.mem[{rd_sel, rd_idx}]
                                                       : pmir_pkg::RD_FILL;
    assign lens = st_reg.len;
endmodule : pmir_string_store

/* File: design/pmir_regs.sv */
// Ident and telemetry command bank of the management bus slave
//
// Behaviour
// R1: 95h reads measured frequency word, enabled only
// R2: Linear-11: exponent 15:11, mantissa 10:0
// R3: 98h byte: part one high, two low
// R4: Spec revision byte reads 22h
// R5: Seven block strings, max 32 bytes, empty
// R6: Strings plus one per command within 128
// R7: Every write since store consumes budget
// R8: Host reclaims budget via restore, write, store
// R9: Write protect rejects string writes
// R10: ADh four bytes: maker, id high/low, reserved
// R11: AEh four bytes: fw major, minor, config
// R12: CEh paged Linear-11 ramp floor, reset zero
`timescale 1ns/1ps
module pmir_regs #(
    // Identity values; arbitrary neutral values
    parameter logic [7:0] MAKER_CODE = 8'h5a,
    parameter logic [7:0] DEVICE_ID_HIGH = 8'h12,
    parameter logic [7:0] DEVICE_ID_LOW = 8'h34,
    parameter logic [7:0] FW_MAJOR = 8'h02,
    parameter logic [7:0] FW_MINOR = 8'h03,
    parameter logic [7:0] FACTORY_CFG = 8'h00
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Command transaction from the bus engine
    input wire logic CMD_START,
    input wire logic [7:0] CMD_CODE,
    input wire logic CMD_STOP,
    input wire logic WR_BYTE_VALID,
    input wire logic [7:0] WR_BYTE,
    input wire logic RD_BYTE_REQ,
    input wire logic PAGE_SEL,
    // Read answer and status
    output logic [7:0] RD_BYTE,
    output logic RD_VALID,
    output logic CMD_REJECTED,
    output logic [7:0] BUDGET_USED,
    // Converter side
    input wire logic CONV_ENABLED,
    input wire logic [15:0] MEAS_FREQ_WORD,
    input wire logic WRITE_PROTECT,
    input wire logic STORE_REQ,
    input wire logic RESTORE_REQ,
    output logic [15:0] RAMP_FLOOR_P0,
    output logic [15:0] RAMP_FLOOR_P1
);
    // Transaction phase: bytes and stop only count inside a transaction
    typedef enum logic {
        ph_idle,
        ph_busy
    } pmir_phase_t;

    typedef struct packed {
        pmir_phase_t phase;
        logic [7:0] cmd;
        logic page;
        logic [5:0] idx;
        logic [5:0] wr_len;
        logic accepted;
        logic [7:0] floor_lo;
        logic [pmir_pkg::PAGE_COUNT-1:0][15:0] floor;
        logic [7:0] used;
        logic [7:0] rd_byte;
        logic rd_valid;
        logic rejected;
    } pmir_state_t;

    pmir_state_t s_reg;
    pmir_state_t s_next;

    // Decoded command and byte position
    logic [2:0] str_sel;
    logic is_str;
    logic is_word;
    logic [4:0] str_wr_idx;
    logic [5:0] rd_data_idx;
    logic [5:0] idx_step;

    // String store hookup
    logic [7:0] str_rd_data;
    logic [pmir_pkg::STR_COUNT-1:0][5:0] str_lens;
    logic str_wr_en;
    logic str_len_set;
    logic [5:0] str_len_val;

    // Budget bookkeeping
    logic [pmir_pkg::STR_COUNT-1:0][7:0] slot_cost;
    logic [7:0] budget_sum;
    logic [8:0] budget_need;
    logic count_refused;

    // Read answers
    logic [7:0] rd_value;
    logic [15:0] freq_word;
    logic [15:0] word_value;
    logic [3:0][7:0] ident_bytes;
    logic [3:0][7:0] fwrev_bytes;

    // String command to slot number; slot 7 means not a string
    always_comb begin
        unique case (s_reg.cmd)
            pmir_pkg::CMD_MAKER_STR: str_sel = 3'h0;
            pmir_pkg::CMD_MODEL_STR: str_sel = 3'h1;
            pmir_pkg::CMD_VERSION_STR: str_sel = 3'h2;
            pmir_pkg::CMD_SITE_STR: str_sel = 3'h3;
            pmir_pkg::CMD_BUILD_DAY_STR: str_sel = 3'h4;
            pmir_pkg::CMD_UNIT_NUM_STR: str_sel = 3'h5;
            pmir_pkg::CMD_SCRATCH_STR: str_sel = 3'h6;
            default: str_sel = 3'h7;
        endcase
    end

    // Strings are the only block writes this bank takes
    assign is_str = (str_sel != 3'h7);

    // Byte position inside data, past the leading count byte
    assign rd_data_idx = s_reg.idx - 6'h01;
    assign str_wr_idx = rd_data_idx[4:0];
    // Index stops at its top so a runaway host cannot wrap it to zero
    assign idx_step = (s_reg.idx == 6'h3f) ? s_reg.idx : s_reg.idx + 6'h01;

    // Frequency only meaningful while switching; reads zero otherwise
    assign freq_word = CONV_ENABLED ? MEAS_FREQ_WORD : 16'h0000; // see R1

    // Identity block by byte position; byte 0 is reserved and reads zero
    assign ident_bytes[3] = MAKER_CODE; // see R10
    assign ident_bytes[2] = DEVICE_ID_HIGH;
    assign ident_bytes[1] = DEVICE_ID_LOW;
    assign ident_bytes[0] = 8'h00;
    // Firmware block by byte position; byte 0 is reserved as well
    assign fwrev_bytes[3] = FW_MAJOR; // see R11
    assign fwrev_bytes[2] = FW_MINOR;
    assign fwrev_bytes[1] = FACTORY_CFG;
    assign fwrev_bytes[0] = 8'h00;

    // Two-byte answers share one path; both go out low byte first
    always_comb begin
        word_value = 16'h0000;
        is_word = 1'b0;
        unique case (s_reg.cmd)
            pmir_pkg::CMD_MEAS_FREQ: begin
                word_value = freq_word; // see R1
                is_word = 1'b1;
            end
            pmir_pkg::CMD_RAMP_FLOOR: begin
                word_value = s_reg.floor[s_reg.page]; // see R12
                is_word = 1'b1;
            end
            default: begin
                word_value = 16'h0000;
                is_word = 1'b0;
            end
        endcase
    end

    // Cost of each held string: its length plus one byte of overhead
    always_comb begin
        slot_cost = '0;
        for (int i = 0; i < pmir_pkg::STR_COUNT; i++) begin
            if (str_lens[i] != 6'h00) begin
                slot_cost[i] = 8'(str_lens[i]) + pmir_pkg::STR_OVERHEAD; // see R6
            end else begin
                slot_cost[i] = 8'h00;
            end
        end
    end

    // Occupancy of what is held now; empty strings cost nothing
    always_comb begin
        budget_sum = 8'h00;
        for (int i = 0; i < pmir_pkg::STR_COUNT; i++) begin
            budget_sum = budget_sum + slot_cost[i];
        end
    end

    // Budget after charging a requested block write length
    assign budget_need = 9'(s_reg.used) + 9'(WR_BYTE) + 9'(pmir_pkg::STR_OVERHEAD);

    // Verdict on a string count byte; nothing is charged when refused
    always_comb begin
        count_refused = 1'b0;
        if (WRITE_PROTECT) begin
            count_refused = 1'b1; // see R9
        end else if (WR_BYTE > 8'(pmir_pkg::STR_MAX_LEN_B)) begin
            count_refused = 1'b1; // see R5
        end else if (budget_need > pmir_pkg::STR_BUDGET) begin
            count_refused = 1'b1; // see R6
        end
    end

    // Read byte selection: words low byte first, blocks lead with a count
    always_comb begin
        rd_value = pmir_pkg::RD_FILL;
        if (is_str) begin
            if (s_reg.idx == 6'h00) begin
                rd_value = 8'(str_lens[str_sel]); // see R5
            end else if (rd_data_idx < str_lens[str_sel]) begin
                rd_value = str_rd_data;
            end
        end else if (is_word) begin
            if (s_reg.idx == 6'h00) begin
                rd_value = word_value[7:0]; // see R2
            end else if (s_reg.idx == 6'h01) begin
                rd_value = word_value[15:8];
            end
        end else begin
            unique case (s_reg.cmd)
                pmir_pkg::CMD_SPEC_VER: begin
                    if (s_reg.idx == 6'h00) begin
                        rd_value = pmir_pkg::SPEC_VER_VALUE; // see R3, R4
                    end
                end
                pmir_pkg::CMD_CHIP_IDENTITY: begin
                    unique case (s_reg.idx)
                        6'h00: rd_value = 8'(pmir_pkg::BLOCK4_LEN); // see R10
                        6'h01: rd_value = ident_bytes[0];
                        6'h02: rd_value = ident_bytes[1];
                        6'h03: rd_value = ident_bytes[2];
                        6'h04: rd_value = ident_bytes[3];
                        default: rd_value = pmir_pkg::RD_FILL;
                    endcase
                end
                pmir_pkg::CMD_CHIP_FW_VER: begin
                    unique case (s_reg.idx)
                        6'h00: rd_value = 8'(pmir_pkg::BLOCK4_LEN); // see R11
                        6'h01: rd_value = fwrev_bytes[0];
                        6'h02: rd_value = fwrev_bytes[1];
                        6'h03: rd_value = fwrev_bytes[2];
                        6'h04: rd_value = fwrev_bytes[3];
                        default: rd_value = pmir_pkg::RD_FILL;
                    endcase
                end
                default: rd_value = pmir_pkg::RD_FILL;
            endcase
        end
    end

    // Transaction sequencing, budget, page floor and read answers
    always_comb begin
        s_next = s_reg;
        s_next.rd_valid = 1'b0;
        s_next.rejected = 1'b0;
        str_wr_en = 1'b0;
        str_len_set = 1'b0;
        str_len_val = pmir_pkg::STR_LEN_RESET;

        // Store or restore ends the accumulation; held strings still count
        if (STORE_REQ || RESTORE_REQ) begin
            s_next.used = budget_sum; // see R7, R8
        end

        if (CMD_START) begin
            s_next.phase = ph_busy;
            s_next.cmd = CMD_CODE;
            s_next.page = PAGE_SEL;
            s_next.idx = 6'h00;
            s_next.accepted = 1'b0;
            s_next.wr_len = 6'h00;
        end else if (s_reg.phase == ph_busy && WR_BYTE_VALID) begin
            s_next.idx = idx_step;
            if (is_str) begin
                if (s_reg.idx == 6'h00) begin
                    // Count byte decides acceptance before any data lands
                    if (count_refused) begin
                        s_next.rejected = 1'b1; // see R9
                    end else begin
                        s_next.accepted = 1'b1;
                        s_next.wr_len = WR_BYTE[5:0];
                        // Charge adds on top of any store this cycle
                        s_next.used = s_next.used + WR_BYTE + pmir_pkg::STR_OVERHEAD; // see R7
                    end
                end else if (s_reg.accepted && rd_data_idx < s_reg.wr_len) begin
                    str_wr_en = 1'b1;
                end
            end else if (s_reg.cmd == pmir_pkg::CMD_RAMP_FLOOR) begin
                if (s_reg.idx == 6'h00) begin
                    s_next.floor_lo = WR_BYTE;
                end else if (s_reg.idx == 6'h01) begin
                    if (WRITE_PROTECT) begin
                        s_next.rejected = 1'b1; // see R12
                    end else begin
                        s_next.floor[s_reg.page] = {WR_BYTE, s_reg.floor_lo}; // see R12
                    end
                end
            end else if (s_reg.idx == 6'h00) begin
                // Read-only or unknown command: writes have no effect
                s_next.rejected = 1'b1;
            end
        end else if (s_reg.phase == ph_busy && RD_BYTE_REQ) begin
            s_next.rd_byte = rd_value;
            s_next.rd_valid = 1'b1;
            s_next.idx = idx_step;
        end else if (s_reg.phase == ph_busy && CMD_STOP) begin
            s_next.phase = ph_idle;
            // Short block: length is what actually arrived
            if (is_str && s_reg.accepted) begin
                str_len_set = 1'b1;
                str_len_val = (rd_data_idx < s_reg.wr_len) ? rd_data_idx : s_reg.wr_len;
                if (s_reg.idx == 6'h00) begin
                    str_len_val = 6'h00;
                end
            end
        end
    end

    // One register stage for all control state
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            s_reg <= '0;
            s_reg.floor <= {pmir_pkg::RAMP_FLOOR_RESET, pmir_pkg::RAMP_FLOOR_RESET};
            s_reg.used <= pmir_pkg::BUDGET_RESET;
            s_reg.rd_byte <= pmir_pkg::RD_FILL;
        end else begin
            s_reg <= s_next;
        end
    end

    // String bytes live in their own array module
    pmir_string_store u_store (
        .clk(REF_CLK),
        .rst(RST),
        .wr_en(str_wr_en),
        .wr_sel(str_sel),
        .wr_idx(str_wr_idx),
        .wr_data(WR_BYTE),
        .len_set(str_len_set),
        .len_val(str_len_val),
        .rd_sel(str_sel),
        .rd_idx(str_wr_idx),
        .rd_data(str_rd_data),
        .lens(str_lens)
    );

    // Outputs straight from the state register
    assign RD_BYTE = s_reg.rd_byte;
    assign RD_VALID = s_reg.rd_valid;
    assign CMD_REJECTED = s_reg.rejected;
    assign BUDGET_USED = s_reg.used;

    // One floor per page, each held until its own page is written
    assign RAMP_FLOOR_P0 = s_reg.floor[0];
    assign RAMP_FLOOR_P1 = s_reg.floor[1];
endmodule : pmir_regs

/* File: sim/pmir_regs_monitor.sv */
// Port checker for the ident and telemetry command bank
`timescale 1ns/1ps
module pmir_regs_monitor (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Host side
    input wire logic CMD_START,
    input wire logic [7:0] CMD_CODE,
    input wire logic WR_BYTE_VALID,
    input wire logic RD_BYTE_REQ,
    input wire logic [7:0] RD_BYTE,
    input wire logic RD_VALID,
    input wire logic CMD_REJECTED,
    input wire logic [7:0] BUDGET_USED,
    // Converter side
    input wire logic CONV_ENABLED,
    input wire logic [15:0] MEAS_FREQ_WORD,
    input wire logic WRITE_PROTECT,
    input wire logic STORE_REQ,
    input wire logic RESTORE_REQ,
    input wire logic [15:0] RAMP_FLOOR_P0,
    input wire logic [15:0] RAMP_FLOOR_P1
);
    logic [7:0] code_reg;
    logic [2:0] rcnt_reg;
    logic wrote_reg;
    logic wr_now;
    logic ro_code;
    logic str_code;
    logic [7:0] freq_lo;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // Bytes only count when no start shares their cycle, as start has priority
    assign wr_now = WR_BYTE_VALID && !CMD_START;
    assign ro_code = code_reg inside {8'h95, 8'h98, 8'had, 8'hae};
    assign str_code = code_reg inside {[8'h99:8'h9e], 8'hb0};
    assign freq_lo = MEAS_FREQ_WORD[7:0];
    // Current command and byte position
    always_ff @(posedge REF_CLK) begin
        if (RST || CMD_START) begin
            code_reg <= CMD_CODE;
            rcnt_reg <= 3'h0;
            wrote_reg <= 1'b0;
        end else begin
            wrote_reg <= wrote_reg || wr_now;
            rcnt_reg <= rcnt_reg + {2'h0, RD_BYTE_REQ && !WR_BYTE_VALID};
        end
    end
    a_valid_cause: assert property (
        RD_VALID |-> $past(RD_BYTE_REQ)) else $error("read answer without request");
    a_spec_byte: assert property (
        RD_VALID && code_reg == 8'h98 && rcnt_reg == 3'h1 |-> RD_BYTE == 8'h22)
        else $error("spec revision byte wrong");
    a_freq_low: assert property (
        RD_VALID && code_reg == 8'h95 && rcnt_reg == 3'h1
        |-> RD_BYTE == ($past(CONV_ENABLED) ? $past(freq_lo) : 8'h00))
        else $error("frequency low byte wrong");
    a_ro_refused: assert property (
        wr_now && !wrote_reg && ro_code |=> CMD_REJECTED) else $error("read-only write taken");
    a_wp_string: assert property (
        wr_now && !wrote_reg && str_code && WRITE_PROTECT |=> CMD_REJECTED)
        else $error("protected string write taken");
    a_wp_floor: assert property (
        WRITE_PROTECT |=> $stable(RAMP_FLOOR_P0) && $stable(RAMP_FLOOR_P1))
        else $error("protected ramp floor changed");
    a_wp_budget: assert property (
        WRITE_PROTECT && !STORE_REQ && !RESTORE_REQ |=> $stable(BUDGET_USED))
        else $error("budget charged while protected");
    a_budget_cap: assert property (
        BUDGET_USED <= 8'h80) else $error("budget above limit");
    a_floor_reset: assert property (
        $fell(RST) |-> RAMP_FLOOR_P0 == 16'h0000 && RAMP_FLOOR_P1 == 16'h0000)
        else $error("ramp floor not cleared by reset");
endmodule : pmir_regs_monitor

/* File: sim/pmir_host_model.sv */
// Bus host model issuing command transactions to the bank
`timescale 1ns/1ps
module pmir_host_model (
    // Clock
    input wire logic clk,
    // Answers
    input wire logic [7:0] rd_byte,
    input wire logic rd_valid,
    input wire logic cmd_rejected,
    // Transaction lines
    output logic cmd_start,
    output logic [7:0] cmd_code,
    output logic cmd_stop,
    output logic wr_byte_valid,
    output logic [7:0] wr_byte,
    output logic rd_byte_req,
    output logic page_sel,
    output logic store_req,
    output logic restore_req
);
    // Idle lines; released data lines flip so a stale value is never reused
    initial begin
        {cmd_start, cmd_code, cmd_stop, wr_byte_valid, wr_byte} = '0;
        {rd_byte_req, page_sel, store_req, restore_req} = '0;
    end
    task automatic begin_cmd(input logic [7:0] c, input logic p);
        @(posedge clk) #1;
        {cmd_start, cmd_code, page_sel} = {1'b1, c, p};
        @(posedge clk) #1;
        {cmd_start, cmd_code, page_sel} = {1'b0, ~c, ~p};
    endtask : begin_cmd
    task automatic end_cmd;
        @(posedge clk) #1;
        cmd_stop = 1'b1;
        @(posedge clk) #1;
        cmd_stop = 1'b0;
    endtask : end_cmd
    task automatic wr(input logic [7:0] b, output logic rej);
        @(posedge clk) #1;
        {wr_byte_valid, wr_byte} = {1'b1, b};
        @(posedge clk) #1;
        {wr_byte_valid, wr_byte} = {1'b0, ~b};
        rej = cmd_rejected;
    endtask : wr
    // Answer is a one-cycle pulse, so it is looked at right after each edge
    task automatic rd(output logic [7:0] d, output bit ok);
        int n;
        @(posedge clk) #1;
        rd_byte_req = 1'b1;
        @(posedge clk) #1;
        rd_byte_req = 1'b0;
        for (n = 0; n < 4 && rd_valid !== 1'b1; n++) @(posedge clk) #1;
        ok = (rd_valid === 1'b1);
        d = rd_byte;
    endtask : rd
    // Store or restore; either one reclaims budget that rewrites charged
    task automatic nv(input logic r);
        @(posedge clk) #1;
        {store_req, restore_req} = {~r, r};
        @(posedge clk) #1;
        {store_req, restore_req} = 2'b00;
    endtask : nv
endmodule : pmir_host_model

/* File: sim/tb_top.sv */
// Testbench for the ident and telemetry command bank
`timescale 1ns/1ps
module tb_top;
    typedef logic [7:0] pmir_bytes_t[$];
    logic clk = 1'b0, rst = 1'b1, conv_en = 1'b0, wp = 1'b0;
    logic [15:0] meas = 16'h0000;
    logic start, stop, wvld, rreq, page, store, restore, rvld, rej;
    logic [7:0] code, wbyte, rbyte, used;
    logic [15:0] fl0, fl1;
    int err_count = 0, checked = 0;
    always #50 clk = ~clk;
    pmir_regs u_dut (.REF_CLK(clk), .RST(rst), .CMD_START(start), .CMD_CODE(code),
        .CMD_STOP(stop), .WR_BYTE_VALID(wvld), .WR_BYTE(wbyte), .RD_BYTE_REQ(rreq),
        .PAGE_SEL(page), .RD_BYTE(rbyte), .RD_VALID(rvld), .CMD_REJECTED(rej),
        .BUDGET_USED(used), .CONV_ENABLED(conv_en), .MEAS_FREQ_WORD(meas),
        .WRITE_PROTECT(wp), .STORE_REQ(store), .RESTORE_REQ(restore),
        .RAMP_FLOOR_P0(fl0), .RAMP_FLOOR_P1(fl1));
    pmir_host_model u_host (.clk(clk), .rd_byte(rbyte), .rd_valid(rvld), .cmd_rejected(rej),
        .cmd_start(start), .cmd_code(code), .cmd_stop(stop), .wr_byte_valid(wvld),
        .wr_byte(wbyte), .rd_byte_req(rreq), .page_sel(page), .store_req(store),
        .restore_req(restore));
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rseq(input logic [7:0] c, input logic p, input pmir_bytes_t e);
        logic [7:0] d;
        bit ok;
        u_host.begin_cmd(c, p);
        foreach (e[i]) begin
            u_host.rd(d, ok);
            if (!ok) begin
                err_count++;
                $display("CHECK FAILED at %0t: no read answer", $time);
                close_out();
            end
            chk(d, e[i]);
        end
        u_host.end_cmd();
    endtask : rseq
    // Refusal of any byte in the transaction counts
    task automatic wchk(input logic [7:0] c, input logic p, input pmir_bytes_t q, input bit er);
        bit any;
        logic r;
        any = 1'b0;
        u_host.begin_cmd(c, p);
        foreach (q[i]) begin
            u_host.wr(q[i], r);
            any |= (r === 1'b1);
        end
        u_host.end_cmd();
        chk(16'(any), 16'(er));
    endtask : wchk
    // Block string: count byte then n letters
    function automatic pmir_bytes_t mk(input int n);
        mk = {8'(n)};
        for (int i = 0; i < n; i++) mk.push_back(8'h41 + 8'(i));
    endfunction : mk
    initial begin
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        chk(fl0, 16'h0000);
        chk(16'(used), 16'h0000);
        rseq(8'hce, 1'b0, '{8'h00, 8'h00});
        rseq(8'h99, 1'b0, '{8'h00});
        rseq(8'h9e, 1'b0, '{8'h00});
        $display("test reset done");
        rseq(8'h98, 1'b0, '{8'h22});
        rseq(8'had, 1'b0, '{8'h04, 8'h00, 8'h34, 8'h12, 8'h5a});
        rseq(8'hae, 1'b0, '{8'h04, 8'h00, 8'h00, 8'h03, 8'h02});
        wchk(8'h98, 1'b0, '{8'h01}, 1'b1);
        wchk(8'had, 1'b0, '{8'h01}, 1'b1);
        {conv_en, meas} = {1'b1, 16'hf2a5};
        rseq(8'h95, 1'b0, '{8'ha5, 8'hf2});
        conv_en = 1'b0;
        rseq(8'h95, 1'b0, '{8'h00, 8'h00});
        $display("test read-only done");
        wchk(8'h99, 1'b0, mk(2), 1'b0);
        chk(16'(used), 16'h0003);
        rseq(8'h99, 1'b0, '{8'h02, 8'h41, 8'h42});
        wchk(8'h99, 1'b0, mk(2), 1'b0);
        chk(16'(used), 16'h0006);
        u_host.nv(1'b1);
        chk(16'(used), 16'h0003);
        wchk(8'h9a, 1'b0, mk(33), 1'b1);
        wp = 1'b1;
        wchk(8'hb0, 1'b0, mk(1), 1'b1);
        chk(16'(used), 16'h0003);
        wp = 1'b0;
        $display("test strings done");
        for (int k = 0; k < 3; k++) wchk(8'h9a + 8'(k), 1'b0, mk(32), 1'b0);
        wchk(8'h9d, 1'b0, mk(26), 1'b1);
        wchk(8'h9d, 1'b0, mk(25), 1'b0);
        chk(16'(used), 16'h0080);
        u_host.nv(1'b0);
        chk(16'(used), 16'h0080);
        $display("test budget done");
        wchk(8'hce, 1'b1, '{8'h34, 8'hf1}, 1'b0);
        chk(fl1, 16'hf134);
        chk(fl0, 16'h0000);
        rseq(8'hce, 1'b1, '{8'h34, 8'hf1});
        wp = 1'b1;
        wchk(8'hce, 1'b0, '{8'h11, 8'h22}, 1'b1);
        chk(fl0, 16'h0000);
        wp = 1'b0;
        $display("test ramp floor done");
        close_out();
    end
endmodule : tb_top
bind pmir_regs pmir_regs_monitor u_mon (.REF_CLK(REF_CLK), .RST(RST), .CMD_START(CMD_START),
    .CMD_CODE(CMD_CODE), .WR_BYTE_VALID(WR_BYTE_VALID), .RD_BYTE_REQ(RD_BYTE_REQ),
    .RD_BYTE(RD_BYTE), .RD_VALID(RD_VALID), .CMD_REJECTED(CMD_REJECTED),
    .BUDGET_USED(BUDGET_USED), .CONV_ENABLED(CONV_ENABLED), .MEAS_FREQ_WORD(MEAS_FREQ_WORD),
    .WRITE_PROTECT(WRITE_PROTECT), .STORE_REQ(STORE_REQ), .RESTORE_REQ(RESTORE_REQ),
    .RAMP_FLOOR_P0(RAMP_FLOOR_P0), .RAMP_FLOOR_P1(RAMP_FLOOR_P1));
